// >>> src/jps_tap.sv
// test access port controller with strap latch and shared return clock pin
`default_nettype none
module jps_tap
#(
    parameter int IrWidth = jps_pkg::JPS_IR_WIDTH,
    parameter int DrWidth = jps_pkg::JPS_DR_WIDTH
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clkEn,
    // test pins
    input  wire logic tckPin,
    input  wire logic tmsPin,
    input  wire logic tdiPin,
    input  wire logic trstNPin,
    input  wire logic ctrlSelPin,
    output var  logic tdoOut,
    output var  logic tdoOe,
    // shared pin
    input  wire logic oneWireEnable,
    input  wire logic oneWireData,
    input  wire logic oneWireDriveLow,
    output var  logic sharedPinOut,
    output var  logic sharedPinOe,
    // status
    output var  logic debugSelected,
    output var  logic inReset
);
    import jps_pkg::*;

    jps_pin_if pins ();

    jps_pin_sync u_sync (
        .clk      (clk),
        .reset    (reset),
        .clkEn    (clkEn),
        .tckPin   (tckPin),
        .tmsPin   (tmsPin),
        .tdiPin   (tdiPin),
        .trstNPin (trstNPin),
        .strapPin (ctrlSelPin),
        .pins     (pins)
    );

    // ==========================================================
    // state
    jps_state_t           state_r;
    jps_state_t           state_nxt;
    logic [IrWidth-1:0]   ir_r;
    logic [IrWidth-1:0]   ir_nxt;
    logic [IrWidth-1:0]   irShift_r;
    logic [IrWidth-1:0]   irShift_nxt;
    logic [DrWidth-1:0]   dr_r;
    logic [DrWidth-1:0]   dr_nxt;
    logic                 tdo_r;
    logic                 tdo_nxt;
    logic                 tdoOe_r;
    logic                 tdoOe_nxt;
    logic                 trstLast_r;
    logic                 trstLast_nxt;
    logic                 sel_r;
    logic                 sel_nxt;
    logic                 pin_r;
    logic                 pin_nxt;
    logic                 pinOe_r;
    logic                 pinOe_nxt;
    logic                 rst_r;
    logic                 rst_nxt;

    function automatic jps_state_t nextState(input jps_state_t s, input logic m);
        unique case (s)
            JPS_RESET:    nextState = m ? JPS_RESET    : JPS_IDLE;
            JPS_IDLE:     nextState = m ? JPS_SEL_DR   : JPS_IDLE;
            JPS_SEL_DR:   nextState = m ? JPS_SEL_IR   : JPS_CAP_DR;
            JPS_CAP_DR:   nextState = m ? JPS_EXIT1_DR : JPS_SHIFT_DR;
            JPS_SHIFT_DR: nextState = m ? JPS_EXIT1_DR : JPS_SHIFT_DR;
            JPS_EXIT1_DR: nextState = m ? JPS_UPD_DR   : JPS_PAUSE_DR;
            JPS_PAUSE_DR: nextState = m ? JPS_EXIT2_DR : JPS_PAUSE_DR;
            JPS_EXIT2_DR: nextState = m ? JPS_UPD_DR   : JPS_SHIFT_DR;
            JPS_UPD_DR:   nextState = m ? JPS_SEL_DR   : JPS_IDLE;
            JPS_SEL_IR:   nextState = m ? JPS_RESET    : JPS_CAP_IR;
            JPS_CAP_IR:   nextState = m ? JPS_EXIT1_IR : JPS_SHIFT_IR;
            JPS_SHIFT_IR: nextState = m ? JPS_EXIT1_IR : JPS_SHIFT_IR;
            JPS_EXIT1_IR: nextState = m ? JPS_UPD_IR   : JPS_PAUSE_IR;
            JPS_PAUSE_IR: nextState = m ? JPS_EXIT2_IR : JPS_PAUSE_IR;
            JPS_EXIT2_IR: nextState = m ? JPS_UPD_IR   : JPS_SHIFT_IR;
            JPS_UPD_IR:   nextState = m ? JPS_SEL_DR   : JPS_IDLE;
        endcase
    endfunction

    // ==========================================================
    // next-state logic
    always_comb begin
        state_nxt    = state_r;
        ir_nxt       = ir_r;
        irShift_nxt  = irShift_r;
        dr_nxt       = dr_r;
        tdo_nxt      = tdo_r;
        tdoOe_nxt    = tdoOe_r;
        trstLast_nxt = pins.trstN;
        sel_nxt      = sel_r;
        // strap caught on release of test reset
        if (pins.trstN && !trstLast_r) begin
            sel_nxt = pins.strap;
        end
        if (!pins.trstN) begin
            state_nxt   = JPS_RESET;
            ir_nxt      = IrWidth'(JPS_IR_RESET);
            irShift_nxt = '0;
            tdoOe_nxt   = 1'b0;
        end else if (pins.tckRise) begin
            state_nxt = nextState(state_r, pins.tms);
            unique case (state_r)
                JPS_CAP_IR: irShift_nxt = IrWidth'(JPS_IR_RESET);
                JPS_SHIFT_IR: irShift_nxt = {pins.tdi, irShift_r[IrWidth-1:1]};
                JPS_UPD_IR:   ir_nxt = irShift_r;
                JPS_CAP_DR: begin
                    dr_nxt = (ir_r == IrWidth'(JPS_IR_IDCODE)) ?
                             DrWidth'(JPS_IDCODE_VALUE) : '0;
                end
                JPS_SHIFT_DR: begin
                    if (ir_r == IrWidth'(JPS_IR_BYPASS)) begin
                        dr_nxt = {{(DrWidth-1){1'b0}}, pins.tdi};
                    end else begin
                        dr_nxt = {pins.tdi, dr_r[DrWidth-1:1]};
                    end
                end
                default: ;
            endcase
            if (state_r == JPS_RESET && pins.tms) begin
                ir_nxt = IrWidth'(JPS_IR_RESET);
            end
        end else if (pins.tckFall) begin
            tdoOe_nxt = (state_r == JPS_SHIFT_DR) || (state_r == JPS_SHIFT_IR);
            tdo_nxt   = (state_r == JPS_SHIFT_IR) ? irShift_r[0] : dr_r[0];
        end
        // shared pin: one-wire wins when enabled, else return clock
        if (oneWireEnable) begin
            pin_nxt   = oneWireData;
            pinOe_nxt = oneWireDriveLow;
        end else begin
            pin_nxt   = pins.tckLevel;
            pinOe_nxt = 1'b1;
        end
        // status follows the controller's reset state
        rst_nxt = (state_nxt == JPS_RESET);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r    <= JPS_RESET;
            ir_r       <= IrWidth'(JPS_IR_RESET);
            irShift_r  <= '0;
            dr_r       <= '0;
            tdo_r      <= 1'b0;
            tdoOe_r    <= 1'b0;
            trstLast_r <= 1'b1;
            sel_r      <= 1'b1;
            pin_r      <= 1'b0;
            pinOe_r    <= 1'b0;
            rst_r      <= 1'b1;
        end else if (clkEn) begin
            state_r    <= state_nxt;
            ir_r       <= ir_nxt;
            irShift_r  <= irShift_nxt;
            dr_r       <= dr_nxt;
            tdo_r      <= tdo_nxt;
            tdoOe_r    <= tdoOe_nxt;
            trstLast_r <= trstLast_nxt;
            sel_r      <= sel_nxt;
            pin_r      <= pin_nxt;
            pinOe_r    <= pinOe_nxt;
            rst_r      <= rst_nxt;
        end
    end

    assign tdoOut        = tdo_r;
    assign tdoOe         = tdoOe_r;
    assign sharedPinOut  = pin_r;
    assign sharedPinOe   = pinOe_r;
    assign debugSelected = sel_r;
    assign inReset       = rst_r;

    // ==========================================================
    // assertions
    property p_trst_reset;
        @(posedge clk) disable iff (reset)
        (clkEn && !pins.trstN) |=> (state_r == JPS_RESET && !tdoOe_r);
    endproperty
    a_trst_reset: assert property (p_trst_reset) else $error("no reset on test reset");

    property p_tdo_fall;
        @(posedge clk) disable iff (reset)
        (clkEn && $past(clkEn) && tdo_r != $past(tdo_r)) |-> $past(pins.tckFall);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off fall");

    property p_tdi_rise;
        @(posedge clk) disable iff (reset)
        (clkEn && pins.trstN && pins.tckRise && state_r == JPS_SHIFT_DR
         && ir_r != IrWidth'(JPS_IR_BYPASS)) |=> (dr_r[DrWidth-1] == $past(pins.tdi));
    endproperty
    a_tdi_rise: assert property (p_tdi_rise) else $error("tdi not shifted");

    property p_tms_step;
        @(posedge clk) disable iff (reset)
        (clkEn && pins.trstN && !pins.tckRise) |=> (state_r == $past(state_r));
    endproperty
    a_tms_step: assert property (p_tms_step) else $error("state moved without edge");

    property p_tms_rise;
        @(posedge clk) disable iff (reset)
        (clkEn && pins.trstN && pins.tckRise && state_r == JPS_IDLE && pins.tms)
        |=> (state_r == JPS_SEL_DR);
    endproperty
    a_tms_rise: assert property (p_tms_rise) else $error("tms step wrong");

    property p_strap;
        @(posedge clk) disable iff (reset)
        (clkEn && pins.trstN && !trstLast_r) |=> (sel_r == $past(pins.strap));
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");

    property p_strap_hold;
        @(posedge clk) disable iff (reset)
        (clkEn && !(pins.trstN && !trstLast_r)) |=> $stable(sel_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");

    property p_onewire;
        @(posedge clk) disable iff (reset)
        (clkEn && oneWireEnable) |=> (pin_r == $past(oneWireData));
    endproperty
    a_onewire: assert property (p_onewire) else $error("one-wire lost pin");

    property p_ret_clk;
        @(posedge clk) disable iff (reset)
        (clkEn && !oneWireEnable) |=> (pinOe_r && pin_r == $past(pins.tckLevel));
    endproperty
    a_ret_clk: assert property (p_ret_clk) else $error("return clock wrong");
endmodule
`default_nettype wire

// >>> src/jps_pkg.sv
// package of constants and types for the test access port select block
//
// Summary of operation
// - The system clock, while its enable is high, times the test logic; test clock edges are detected from synchronised samples.
// - A low test reset resets the controller at once, with no test clock edge needed.
// - The serial test output changes only on falling edges of the test clock.
// - The serial test input is sampled on rising edges of the test clock.
// - The mode select input, sampled on rising test clock edges, steps the controller.
// - The select strap is caught as test reset is released and held until the next release.
// - Return clock and one-wire function share one pin; only one can be used at a time.
`default_nettype none
package jps_pkg;
    // ==========================================================
    // widths and reset values
    localparam int          JPS_IR_WIDTH     = 4;
    localparam int          JPS_DR_WIDTH     = 32;
    localparam int          JPS_SYNC_STAGES  = 2;
    localparam logic [3:0]  JPS_IR_RESET     = 4'h1;
    localparam logic [3:0]  JPS_IR_BYPASS    = 4'hF;
    localparam logic [3:0]  JPS_IR_IDCODE    = 4'h1;
    // identity value is arbitrary
    localparam logic [31:0] JPS_IDCODE_VALUE = 32'h1234_5001;

    // ==========================================================
    // controller states
    typedef enum logic [3:0] {
        JPS_RESET, JPS_IDLE, JPS_SEL_DR, JPS_CAP_DR, JPS_SHIFT_DR, JPS_EXIT1_DR,
        JPS_PAUSE_DR, JPS_EXIT2_DR, JPS_UPD_DR, JPS_SEL_IR, JPS_CAP_IR,
        JPS_SHIFT_IR, JPS_EXIT1_IR, JPS_PAUSE_IR, JPS_EXIT2_IR, JPS_UPD_IR
    } jps_state_t;
endpackage
`default_nettype wire

// >>> src/jps_pin_if.sv
// interface carrying synchronised test pins and detected test clock edges
`default_nettype none
interface jps_pin_if;
    logic tckLevel;
    logic tckRise;
    logic tckFall;
    logic tms;
    logic tdi;
    logic trstN;
    logic strap;
    modport src (output tckLevel, output tckRise, output tckFall, output tms, output tdi,
                 output trstN, output strap);
    modport dst (input tckLevel, input tckRise, input tckFall, input tms, input tdi,
                 input trstN, input strap);
endinterface
`default_nettype wire

// >>> src/jps_pin_sync.sv
// two-stage synchronisers for test pins and test clock edge detection
`default_nettype none
module jps_pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clkEn,
    // raw pins
    input  wire logic tckPin,
    input  wire logic tmsPin,
    input  wire logic tdiPin,
    input  wire logic trstNPin,
    input  wire logic strapPin,
    // synchronised side
    jps_pin_if.src    pins
);
    import jps_pkg::*;

    // ==========================================================
    // synchronisers
    logic [4:0] meta_r;
    logic [4:0] meta_nxt;
    logic [4:0] sync_r;
    logic [4:0] sync_nxt;
    logic       tckLast_r;
    logic       tckLast_nxt;

    always_comb begin
        meta_nxt    = {strapPin, trstNPin, tdiPin, tmsPin, tckPin};
        sync_nxt    = meta_r;
        tckLast_nxt = sync_r[0];
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r    <= 5'h18;
            sync_r    <= 5'h18;
            tckLast_r <= 1'b0;
        end else if (clkEn) begin
            meta_r    <= meta_nxt;
            sync_r    <= sync_nxt;
            tckLast_r <= tckLast_nxt;
        end
    end

    assign pins.tckLevel = sync_r[0];
    assign pins.tckRise  = sync_r[0] & ~tckLast_r;
    assign pins.tckFall  = ~sync_r[0] & tckLast_r;
    assign pins.tms      = sync_r[1];
    assign pins.tdi      = sync_r[2];
    assign pins.trstN    = sync_r[3];
    assign pins.strap    = sync_r[4];
endmodule
`default_nettype wire

// >>> dv/jps_probe_model.sv
// debugger probe model driving the test pins
`default_nettype none
module jps_probe_model (
    // test pins driven
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    output var  logic trstN,
    output var  logic strap,
    // test data returned
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime halfT = 62.5;
    // tck stands low outside frames; strap held high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b0;
        strap = 1'b1;
    end
    // ==========================================================
    // one test clock period; tdo taken just before the rise
    task automatic bitStep(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #(halfT);
        q = tdo;
        tck = 1'b1;
        #(halfT);
        tck = 1'b0;
    endtask
    task automatic walk(input logic [31:0] m, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            bitStep(m[i], ~tdi, q);
        end
    endtask
    // shift lsb first, then update and return to idle
    task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = '0;
        for (int i = 0; i < n; i++) begin
            bitStep(i == n - 1, din[i], q);
            dout[i] = q;
        end
        walk(32'h0000_0001, 2);
        tdi = ~tdi;
    endtask
    // test reset pulse with strap value at release, strap then back high
    task automatic testReset(input logic s);
        trstN = 1'b0;
        #(4 * halfT);
        strap = s;
        #(halfT);
        trstN = 1'b1;
        #(halfT);
        strap = 1'b1;
    endtask
    // direct pin levels for scenarios outside a frame
    task automatic setTck(input logic v);
        tck = v;
    endtask
    task automatic setTrst(input logic v);
        trstN = v;
    endtask
endmodule
`default_nettype wire

// >>> dv/test_jtag_port_select.sv
// testbench for the test access port select block
`default_nettype none
module test_jtag_port_select
    import jps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        clkEn = 1'b1;
    logic        oneWireEnable = 1'b0;
    logic        oneWireData = 1'b0;
    logic        oneWireDriveLow = 1'b0;
    wire logic   tck, tms, tdi, trstN, strap;
    logic        tdoOut, tdoOe, sharedPinOut, sharedPinOe, debugSelected, inReset;
    logic [31:0] got;
    int          miscompares = 0;
    int          totalChecks = 0;

    initial begin
        forever #4 clk = ~clk;
    end
    jps_tap u_jps_tap (.clk(clk), .reset(reset), .clkEn(clkEn), .tckPin(tck), .tmsPin(tms),
        .tdiPin(tdi), .trstNPin(trstN), .ctrlSelPin(strap), .tdoOut(tdoOut), .tdoOe(tdoOe),
        .oneWireEnable(oneWireEnable), .oneWireData(oneWireData),
        .oneWireDriveLow(oneWireDriveLow), .sharedPinOut(sharedPinOut),
        .sharedPinOe(sharedPinOe), .debugSelected(debugSelected), .inReset(inReset));
    jps_probe_model u_jps_probe_model (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN),
        .strap(strap), .tdo(tdoOut));
    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic endSim();
        $display("checks=%0d miscompares=%0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic waitShared(input logic v);
        int n;
        n = 0;
        while (sharedPinOut !== v && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(sharedPinOut, v);
        if (sharedPinOut !== v) endSim();
    endtask
    // ==========================================================
    // scenarios
    task automatic tIdcode();
        u_jps_probe_model.testReset(1'b1);
        step(8);
        check(debugSelected, 1'b1);
        u_jps_probe_model.walk(32'h0000_0002, 4);
        step(8);
        check(tdoOe, 1'b1);
        u_jps_probe_model.shift(32'h0, 32, got);
        check(got, JPS_IDCODE_VALUE);
        step(8);
        check(tdoOe, 1'b0);
        check(inReset, 1'b0);
    endtask
    task automatic tBypassSlow();
        u_jps_probe_model.halfT = 200.0;
        u_jps_probe_model.walk(32'h0000_0003, 4);
        u_jps_probe_model.shift({28'h0, JPS_IR_BYPASS}, 4, got);
        check(got, {28'h0, JPS_IR_RESET});
        u_jps_probe_model.walk(32'h0000_0001, 3);
        u_jps_probe_model.shift(32'h0000_00A5, 9, got);
        check(got, 32'h0000_014A);
        u_jps_probe_model.halfT = 62.5;
    endtask
    task automatic tResets();
        u_jps_probe_model.walk(32'h0000_001F, 5);
        step(8);
        check(inReset, 1'b1);
        u_jps_probe_model.walk(32'h0000_0002, 4);
        step(8);
        check(tdoOe, 1'b1);
        u_jps_probe_model.setTrst(1'b0);
        step(8);
        check(inReset, 1'b1);
        check(tdoOe, 1'b0);
    endtask
    task automatic tStrap();
        u_jps_probe_model.testReset(1'b0);
        step(8);
        check(debugSelected, 1'b0);
        u_jps_probe_model.testReset(1'b1);
        step(8);
        check(debugSelected, 1'b1);
    endtask
    task automatic tShared();
        oneWireEnable = 1'b0;
        step(6);
        check(sharedPinOe, 1'b1);
        u_jps_probe_model.setTck(1'b1);
        waitShared(1'b1);
        u_jps_probe_model.setTck(1'b0);
        waitShared(1'b0);
        oneWireEnable = 1'b1;
        for (int v = 0; v < 4; v++) begin
            oneWireData = v[0];
            oneWireDriveLow = v[1];
            u_jps_probe_model.setTck(~v[0]);
            step(6);
            check(sharedPinOut, v[0]);
            check(sharedPinOe, v[1]);
        end
        oneWireEnable = 1'b0;
    endtask
    task automatic tFreeze();
        waitShared(1'b0);
        clkEn = 1'b0;
        u_jps_probe_model.setTck(1'b1);
        step(8);
        check(sharedPinOut, 1'b0);
        clkEn = 1'b1;
        waitShared(1'b1);
        u_jps_probe_model.setTck(1'b0);
        waitShared(1'b0);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        step(12);
        reset = 1'b0;
        check(inReset, 1'b1);
        check(debugSelected, 1'b1);
        check(tdoOe, 1'b0);
        tIdcode();
        tBypassSlow();
        tResets();
        tStrap();
        tShared();
        tFreeze();
        endSim();
    end
    initial begin
        #200us;
        miscompares++;
        endSim();
    end
endmodule
`default_nettype wire
